/* File: hdl/tsu_pkg.sv */
// Constants, register map and state layout for the tick sampled UART.
package tsu_pkg;

  // Clock and line timing.
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned TICKS_PER_BIT = 4;
  localparam logic [15:0] TICK_DIV_RST =
    16'(CLK_HZ / (TICKS_PER_BIT * BAUD_DEFAULT) - 1);

  // Register byte addresses on the APB.
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_TXDATA = 12'h004;
  localparam logic [11:0] ADDR_RXDATA = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;

  // Control register fields.
  localparam int unsigned CTRL_DIV_LSB = 0;
  localparam int unsigned CTRL_EN_BIT  = 16;
  localparam logic        CTRL_EN_RST  = 1'b1;

  // Status register fields.
  localparam int unsigned ST_THE   = 0;
  localparam int unsigned ST_FE    = 1;
  localparam int unsigned ST_OE    = 2;
  localparam int unsigned ST_RFULL = 3;
  localparam int unsigned ST_WFULL = 4;
  localparam int unsigned ST_RXACT = 5;
  localparam int unsigned ST_RXSB  = 6;
  localparam int unsigned ST_RXBD  = 7;
  localparam int unsigned ST_RXRDY = 8;
  localparam int unsigned ST_TXACT = 9;
  localparam int unsigned ST_TXREQ = 10;
  localparam int unsigned ST_TXPIP = 11;
  localparam int unsigned ST_TXSB  = 12;

  // Receiver and transmitter constants.
  localparam logic [7:0] RX_PRESET     = 8'h80;
  localparam logic [2:0] RX_TICK_LOAD  = 3'h4;
  localparam logic [5:0] TX_CNT_DONE   = 6'h28;
  localparam logic [5:0] TX_CNT_STOP   = 6'h24;
  localparam logic [5:0] TX_CNT_INIT   = 6'h01;
  localparam logic       LINE_MARK     = 1'b1;
  localparam logic       LINE_SPACE    = 1'b0;

  // Receive state flags.
  typedef struct packed {
    logic       active;
    logic       start_ok;
    logic       byte_done;
    logic       data_ready;
    logic       frame_err;
    logic       overrun;
    logic [2:0] tick_cnt;
    logic [7:0] deser;
    logic [7:0] hold;
  } tsu_rx_s;

  // Transmit state flags.
  typedef struct packed {
    logic       active;
    logic       request;
    logic       pipe_bit;
    logic       start_bit;
    logic       holding_empty;
    logic [5:0] tick_cnt;
    logic [7:0] ser;
    logic [7:0] hold;
  } tsu_tx_s;

  // Whole state of the top module.
  typedef struct packed {
    tsu_rx_s     rx;
    tsu_tx_s     tx;
    logic [15:0] div;
    logic        en;
    logic [7:0]  wbuf;
    logic        wfull;
    logic [7:0]  rbuf;
    logic        rfull;
    logic        st_fe;
    logic        st_oe;
    logic        txd;
    logic        tick_mon;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tsu_state_s;

endpackage

/* File: hdl/tsu_tick_gen.sv */
// Sampling tick divider that pulses once per divisor period.
`timescale 1ns/10ps
module tsu_tick_gen (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Divider control.
  input  wire logic        en,
  input  wire logic [15:0] div,
  // One cycle tick pulse.
  output logic             tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tsu_tick_s;

  tsu_tick_s st_q;
  tsu_tick_s st_d;

  // Count down and reload, emitting a pulse on each reload from zero; while disabled, reload every cycle without a pulse.
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!nrst) begin
      st_d = '0;
    end else if (!en) begin
      st_d.cnt = div;
    end else if (st_q.cnt == 16'h0000) begin
      st_d.cnt  = div;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  assign tick = st_q.tick;
endmodule

/* File: hdl/tsu_uart.sv */
// Tick sampled UART with APB register access and one byte host buffers.
//
// Behaviour
// - Sampling tick runs at four times baud and times both directions.
// - Idle space sets receiving; confirmed start presets deserializer 80h.
// - After start, count ticks down, sample at zero, reload with four.
// - Data samples rotate in; marker shifted out sets byte finished.
// - Sample after byte finished is stop; space sets framing error.
// - Stop time with data still ready sets overrun error.
// - Then set ready, move byte to holding, clear receive flags.
// - Each tick first drives the pipelined bit onto the line.
// - Tick with start flag set: clear it, init counter, nothing more.
// - Else increment counter and act only when counter mod 4 is zero.
// - Idle without request asserts holding empty bit and pin.
// - Idle with request loads serializer, sets active and start, space out.
// - Active at count 28h clears active: character done.
// - Active at count 24h loads a mark for the stop bit.
// - Other active points shift next data bit into the pipelined bit.
// - Host data write clears holding empty, sets request, fills holding.
// - Read buffer full flag clears when the host reads the buffer.
// - Monitor output toggles on every sampling tick.
//
// Overview
// The tick divider sets the pace of both directions: four ticks make
// one bit cell. Neither direction does anything between ticks apart
// from the buffer transfers, which run every clock.
// The host side has one byte each way: the write buffer feeds the
// transmit holding register one cycle after the write, and the read
// buffer is filled from the receive holding register when it is free.
//
// Receiver walk, counted in ticks from the first space seen:
//   t0      space on an idle line marks a possible start.
//   t1      second space confirms it; a mark instead drops the attempt.
//   t5..t33 one data bit every fourth tick, least significant first.
//   t37     stop sample; framing and overrun decided, character ready.
// A glitch shorter than one tick may be missed or taken as a start;
// the confirm tick filters the second case.
//
// Transmitter walk, counted by its own tick counter:
//   load    on a multiple of four with a pending request; the start
//           space goes into the pipelined bit.
//   start   next tick drives the space and restarts the count at one.
//   4..32   eight data bits are shifted into the pipelined bit.
//   36      a mark for the stop bit.
//   40      character done; the line stays at mark.
// Every line change is launched by a tick, so all bit edges sit at
// the same place after their tick.
//
// Register map, one aligned word each:
//   CTRL    divisor in the low half and enable above it; the tick
//           period is the divisor plus one clocks.
//   TXDATA  host byte for the transmitter; a read returns the last one.
//   RXDATA  received byte; reading it empties the read buffer.
//   STATUS  buffer and error flags plus the internal receive and
//           transmit flags; writing one to framing or overrun clears it.
// An address outside the map answers with slave error; a write there
// is dropped and a read returns zero.
//
// Limitations a user must know:
//   Every access has one wait state; read data stands for one cycle.
//   Holding empty falls one cycle after the host write, so a host that
//   uses it as an interrupt must take it edge sensitive.
//   The transmit counter runs free while idle, so a new character may
//   wait up to four ticks for its start bit.
//   A byte written while another still waits in the holding register
//   replaces it; the host must watch holding empty first.
//   A new divisor takes effect at the next reload; clearing the enable
//   reloads it at once.
//   Error flags reach the status word when their character moves into
//   the read buffer, not at the stop sample.
`timescale 1ns/10ps
module tsu_uart (
  // Clock and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Serial line.
  input  wire logic        RXD,
  output logic             TXD,
  // Status pins.
  output logic             TX_EMPTY,
  output logic             RD_FULL,
  output logic             TICK_MON
);
  import tsu_pkg::*;

  tsu_state_s st_q;
  tsu_state_s st_d;
  logic       tick;
  logic       acc;
  logic       wr_ok;
  logic       rd_ok;
  logic       hit;
  logic       rx_last;
  logic       rx_stop;
  logic [5:0] tx_cnt_inc;
  logic [31:0] status_word;

  // Sampling tick at four times the baud rate.
  tsu_tick_gen u_tick (
    .clk  (CORE_CLK),
    .nrst (NRST),
    .en   (st_q.en),
    .div  (st_q.div),
    .tick (tick)
  );

  // Access phase decode; one wait state before pready.
  // Writes and reads act at the edge where pready is seen high.
  assign acc   = PSEL & PENABLE & st_q.pready;
  assign hit   = (PADDR == ADDR_CTRL) | (PADDR == ADDR_TXDATA) |
                 (PADDR == ADDR_RXDATA) | (PADDR == ADDR_STATUS);
  assign wr_ok = acc & PWRITE & hit;
  assign rd_ok = acc & ~PWRITE & hit;

  // Helper values for the receiver rotate and transmit counter.
  assign rx_last    = st_q.rx.deser[0];
  assign tx_cnt_inc = st_q.tx.tick_cnt + 6'h01;

  // The receiver takes its stop sample in this cycle.
  assign rx_stop = tick & st_q.rx.active & st_q.rx.start_ok &
                   st_q.rx.byte_done & (st_q.rx.tick_cnt == 3'h1);

  // Status word as seen by a read.
  // Bits above the transmit start flag read as zero.
  always_comb begin
    status_word           = '0;
    status_word[ST_THE]   = st_q.tx.holding_empty;
    status_word[ST_FE]    = st_q.st_fe;
    status_word[ST_OE]    = st_q.st_oe;
    status_word[ST_RFULL] = st_q.rfull;
    status_word[ST_WFULL] = st_q.wfull;
    status_word[ST_RXACT] = st_q.rx.active;
    status_word[ST_RXSB]  = st_q.rx.start_ok;
    status_word[ST_RXBD]  = st_q.rx.byte_done;
    status_word[ST_RXRDY] = st_q.rx.data_ready;
    status_word[ST_TXACT] = st_q.tx.active;
    status_word[ST_TXREQ] = st_q.tx.request;
    status_word[ST_TXPIP] = st_q.tx.pipe_bit;
    status_word[ST_TXSB]  = st_q.tx.start_bit;
  end

  // Next state: bus, receiver, transmitter and buffer transfers.
  always_comb begin
    st_d         = st_q;
    // Bus answer: ready rises one cycle after the access phase opens
    // and stands for one cycle; slave error goes with it.
    st_d.pready  = PSEL & PENABLE & ~st_q.pready;
    st_d.pslverr = PSEL & PENABLE & ~st_q.pready & ~hit;
    st_d.prdata  = '0;

    // Read data is prepared in the cycle before pready rises.
    // Outside an answer the read data stays at zero.
    if (PSEL & PENABLE & ~st_q.pready & ~PWRITE) begin
      case (PADDR)
        ADDR_CTRL: begin
          st_d.prdata[CTRL_DIV_LSB +: 16] = st_q.div;
          st_d.prdata[CTRL_EN_BIT]        = st_q.en;
        end
        ADDR_TXDATA: begin
          st_d.prdata[7:0] = st_q.wbuf;
        end
        ADDR_RXDATA: begin
          st_d.prdata[7:0] = st_q.rbuf;
        end
        ADDR_STATUS: begin
          st_d.prdata = status_word;
        end
        default: begin
          st_d.prdata = '0;
        end
      endcase
    end

    // Register writes take effect at the completing edge.
    if (wr_ok) begin
      case (PADDR)
        ADDR_CTRL: begin
          st_d.div = PWDATA[CTRL_DIV_LSB +: 16];
          st_d.en  = PWDATA[CTRL_EN_BIT];
        end
        ADDR_TXDATA: begin
          st_d.wbuf  = PWDATA[7:0];
          st_d.wfull = 1'b1;
        end
        ADDR_STATUS: begin
          // Writing one clears an error flag.
          if (PWDATA[ST_FE]) begin
            st_d.st_fe = 1'b0;
          end
          if (PWDATA[ST_OE]) begin
            st_d.st_oe       = 1'b0;
            st_d.rx.overrun  = 1'b0;
          end
        end
        default: begin
          st_d.en = st_q.en;
        end
      endcase
    end

    // Reading the receive buffer empties it.
    if (rd_ok && PADDR == ADDR_RXDATA) begin
      st_d.rfull = 1'b0;
    end

    if (tick) begin
      // Diagnostic toggle marks each sampling instant.
      st_d.tick_mon = ~st_q.tick_mon;
      // Line changes at the same point after every tick.
      st_d.txd = st_q.tx.pipe_bit;

      // Receiver.
      if (!st_q.rx.active) begin
        if (RXD == LINE_SPACE) begin
          st_d.rx.active = 1'b1;
        end
      end else if (!st_q.rx.start_ok) begin
        if (RXD == LINE_SPACE) begin
          st_d.rx.start_ok = 1'b1;
          st_d.rx.tick_cnt = RX_TICK_LOAD;
          st_d.rx.deser    = RX_PRESET;
        end else begin
          // A mark on the confirm tick was noise; go back to idle.
          st_d.rx.active = 1'b0;
        end
      end else begin
        // A count of one reaches zero on this tick, so that is the
        // sampling tick; the counter then starts over at four.
        st_d.rx.tick_cnt = st_q.rx.tick_cnt - 3'h1;
        if (st_q.rx.tick_cnt == 3'h1) begin
          st_d.rx.tick_cnt = RX_TICK_LOAD;
          if (!st_q.rx.byte_done) begin
            // Rotate right: new bit enters at the top.
            st_d.rx.deser = {RXD, st_q.rx.deser[7:1]};
            if (rx_last) begin
              st_d.rx.byte_done = 1'b1;
            end
          end else begin
            st_d.rx.frame_err = (RXD == LINE_SPACE);
            if (st_q.rx.data_ready) begin
              st_d.rx.overrun = 1'b1;
            end
            st_d.rx.data_ready = 1'b1;
            st_d.rx.hold       = st_q.rx.deser;
            st_d.rx.active     = 1'b0;
            st_d.rx.start_ok   = 1'b0;
            st_d.rx.byte_done  = 1'b0;
          end
        end
      end

      // Transmitter.
      // The start tick restarts the count at one, so the start bit and
      // every data bit last four ticks each.
      if (st_q.tx.start_bit) begin
        st_d.tx.start_bit = 1'b0;
        st_d.tx.tick_cnt  = TX_CNT_INIT;
      end else begin
        st_d.tx.tick_cnt = tx_cnt_inc;
        if (tx_cnt_inc[1:0] == 2'b00) begin
          // Idle: announce an empty holding register or load from it.
          if (!st_q.tx.active) begin
            if (!st_q.tx.request) begin
              st_d.tx.holding_empty = 1'b1;
            end else begin
              st_d.tx.ser           = st_q.tx.hold;
              st_d.tx.request       = 1'b0;
              st_d.tx.active        = 1'b1;
              st_d.tx.start_bit     = 1'b1;
              st_d.tx.pipe_bit      = LINE_SPACE;
              st_d.tx.holding_empty = 1'b1;
            end
          end else if (tx_cnt_inc == TX_CNT_DONE) begin
            st_d.tx.active = 1'b0;
          end else if (tx_cnt_inc == TX_CNT_STOP) begin
            st_d.tx.pipe_bit = LINE_MARK;
          end else begin
            st_d.tx.pipe_bit = st_q.tx.ser[0];
            st_d.tx.ser      = {1'b0, st_q.tx.ser[7:1]};
          end
        end
      end
    end

    // Host byte moves to the transmit holding register; this runs
    // after the tick so a new request is never lost.
    if (st_q.wfull) begin
      st_d.tx.hold          = st_q.wbuf;
      st_d.tx.request       = 1'b1;
      st_d.tx.holding_empty = 1'b0;
      st_d.wfull            = 1'b0;
    end

    // Ready character moves to the read buffer with its errors.
    if (st_q.rx.data_ready && !st_q.rfull) begin
      st_d.rbuf          = st_q.rx.hold;
      st_d.rfull         = 1'b1;
      // A stop sample in this same cycle leaves a new character behind,
      // so its ready and overrun flags survive the move.
      st_d.rx.data_ready = rx_stop;
      if (st_q.rx.frame_err) begin
        st_d.st_fe = 1'b1;
      end
      if (st_q.rx.overrun) begin
        st_d.st_oe      = 1'b1;
        st_d.rx.overrun = rx_stop;
      end
    end

    // Synchronous reset: mark on the line, holding empty set.
    if (!NRST) begin
      st_d                  = '0;
      st_d.txd              = LINE_MARK;
      st_d.tx.pipe_bit      = LINE_MARK;
      st_d.tx.holding_empty = 1'b1;
      st_d.div              = TICK_DIV_RST;
      st_d.en               = CTRL_EN_RST;
    end
  end

  // State register.
  always_ff @(posedge CORE_CLK) begin
    st_q <= st_d;
  end

  // Outputs come straight from the state register.
  assign PRDATA   = st_q.prdata;
  assign PREADY   = st_q.pready;
  assign PSLVERR  = st_q.pslverr;
  assign TXD      = st_q.txd;
  assign TX_EMPTY = st_q.tx.holding_empty;
  assign RD_FULL  = st_q.rfull;
  assign TICK_MON = st_q.tick_mon;
endmodule

/* File: verification/tsu_uart_asserts.sv */
// Port level checks for the tick sampled UART.
`timescale 1ns/10ps
module tsu_uart_asserts
  import tsu_pkg::*;
(
  // Clock and reset.
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  // APB.
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Line and status pins.
  input wire logic        TXD,
  input wire logic        TX_EMPTY,
  input wire logic        RD_FULL,
  input wire logic        TICK_MON
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  // Reset state, then bus timing, then line and pin timing.
  a_reset_idle: assert property (disable iff (1'b0)
    !NRST |=> TXD && TX_EMPTY && !RD_FULL && !TICK_MON)
    else $error("pins not idle after reset");
  a_one_wait: assert property (
    $rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("access not answered after one wait");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_error_map: assert property (
    PREADY |-> PSLVERR == !(PADDR == ADDR_CTRL || PADDR == ADDR_TXDATA ||
                            PADDR == ADDR_RXDATA || PADDR == ADDR_STATUS))
    else $error("slave error does not match address");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  a_empty_falls: assert property (
    PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_TXDATA
    |-> ##[1:3] !TX_EMPTY) else $error("holding empty not cleared");
  a_read_clears: assert property (
    PSEL && PENABLE && PREADY && !PWRITE && PADDR == ADDR_RXDATA
    |-> ##[1:2] !RD_FULL) else $error("read full not cleared");
  a_tick_spacing: assert property (
    $changed(TICK_MON) |=> $stable(TICK_MON) [*3])
    else $error("tick monitor toggled too soon");
  a_txd_on_tick: assert property (
    $changed(TXD) |=> $stable(TXD) [*3])
    else $error("line changed between ticks");
endmodule

bind tsu_uart tsu_uart_asserts u_tsu_uart_asserts (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TXD(TXD), .TX_EMPTY(TX_EMPTY),
  .RD_FULL(RD_FULL), .TICK_MON(TICK_MON)
);

/* File: verification/tsu_line.sv */
// Remote serial line model: sends frames and decodes transmitted ones.
`timescale 1ns/10ps
module tsu_line #(
  parameter int BIT_CLKS = 16
) (
  // Clock.
  input  wire logic       clk,
  // Serial line.
  output logic            rxd,
  input  wire logic       txd,
  // Last decoded byte and frame count.
  output logic [7:0]      got,
  output int              got_cnt
);
  // Line rests at mark.
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_cnt = 0;
  end

  // A space stop bit is cut short so the receiver sees mark after it.
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat ((i == 9 && !stop) ? BIT_CLKS * 3 / 4 : BIT_CLKS)
        @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask

  // Samples each cell at its middle, least significant bit first.
  always begin
    @(negedge txd);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      if (i < 8) got[i] <= txd;
    end
    got_cnt <= got_cnt + 1;
  end
endmodule

/* File: verification/tsu_uart_bench.sv */
// Self-checking bench for the tick sampled UART.
`timescale 1ns/10ps
module tsu_uart_bench;
  import tsu_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        tx_empty;
  logic        rd_full;
  logic        tick_mon;
  logic [7:0]  got;
  int          got_cnt;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [31:0] rd;
  logic        err;

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  // Device and far line.
  tsu_uart u_tsu_uart (
    .CORE_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .TXD(txd),
    .TX_EMPTY(tx_empty), .RD_FULL(rd_full), .TICK_MON(tick_mon)
  );
  tsu_line #(.BIT_CLKS(16)) u_tsu_line (
    .clk(clk), .rxd(rxd), .txd(txd), .got(got), .got_cnt(got_cnt)
  );

  // Verdict and end of run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 600) begin
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      stop_test();
    end
  endtask

  // One APB transfer; request held until ready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 600);
    tmo(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 600);
    tmo(n);
  endtask

  // Edge sensitive host: waits for holding empty to fall, then rise.
  task automatic empty_rise();
    int n;
    n = 0;
    while (tx_empty !== 1'b0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    while (tx_empty !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask

  task automatic frames(input int k);
    int n;
    for (n = 0; n < 600 && got_cnt < k; n++) @(posedge clk);
    tmo(n);
  endtask

  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0801);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    // Clear the enable first so the divider reloads at once.
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    apb(1'b1, ADDR_CTRL, 32'h0001_0003);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0001_0003);
    // Two bytes through the double buffer, polling as a host must.
    apb(1'b1, ADDR_TXDATA, 32'ha5);
    poll(32'h10, 32'h0);
    poll(32'h1, 32'h1);
    apb(1'b1, ADDR_TXDATA, 32'h3c);
    empty_rise();
    chk(32'(got_cnt), 32'h1);
    frames(1);
    chk(32'(got), 32'ha5);
    frames(2);
    chk(32'(got), 32'h3c);
    poll(32'h201, 32'h1);
    // A good character, then one with a space stop bit.
    u_tsu_line.send(8'h5a, 1'b1);
    poll(32'h8, 32'h8);
    chk(rd & 32'h7, 32'h1);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rd, 32'h5a);
    @(posedge clk);
    chk(32'(rd_full), 32'h0);
    u_tsu_line.send(8'h81, 1'b0);
    poll(32'h8, 32'h8);
    chk(rd & 32'h2, 32'h2);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rd, 32'h81);
    apb(1'b1, ADDR_STATUS, 32'h2);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h0);
    // Three unread characters: the third finds data still waiting.
    for (int i = 0; i < 3; i++) u_tsu_line.send(8'h30 + 8'(i), 1'b1);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rd, 32'h30);
    // The third character replaced the second and carries the overrun.
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk(rd, 32'h32);
    stop_test();
  end
endmodule
